// *** rtl/sync_burst_read.sv ***
// Synchronous burst read control: register slave and burst clock data engine.
`timescale 1ns/1ps
//
// Operation
// - Enable bit clear: burst clock ignored, no burst read cycles performed.
// - Enable bit set: burst clock used, reads are synchronous bursts.
// - Invert bit clear: strobes sampled on rising burst clock edge.
// - Invert bit set: strobes sampled on falling edge, first data one clock later.
// - Each data word held one clock, or two when hold bit set.
// - First word available two plus first_word_delay clocks after strobes sampled asserted.
// - With hold set, word latchable on indicated clock and the next.
// - Hold clear: burst moves two to the power length units.
// - Hold set: burst moves two to the power length minus one units, or one unit at length zero.
// - Control bits three to seven are read-only zero.
module sync_burst_read (
	input wire logic I_CLK,
	input wire logic I_RST_B,
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [15:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	output logic [31:0] O_PRDATA,
	output logic O_PREADY,
	output logic O_PSLVERR,
	input wire logic I_BCLK,
	input wire logic I_CE_B,
	input wire logic I_OE_B,
	output logic [15:0] O_D,
	output logic O_D_OE
);
	// ****************************************************************
	// Reset release in both domains
	// ****************************************************************
	logic [1:0] arst_q;
	logic [1:0] lrst_q;
	logic rst_b;
	logic lrst_b;

	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			arst_q <= 2'b00;
		end else begin
			arst_q <= {arst_q[0], 1'b1};
		end
	end

	always_ff @(posedge I_BCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			lrst_q <= 2'b00;
		end else begin
			lrst_q <= {lrst_q[0], 1'b1};
		end
	end

	assign rst_b = arst_q[1];
	assign lrst_b = lrst_q[1];

	// ****************************************************************
	// Register slave
	// ****************************************************************
	logic [15:0] ctrl_q;
	logic [8:0] start_q;
	logic [7:0] wptr_q;
	logic [31:0] prdata_q;
	logic [11:0] stat_a;
	logic hit_ctrl;
	logic hit_wptr;
	logic hit_wdata;
	logic hit_start;
	logic hit_stat;
	logic mapped;
	logic setup;
	logic wr_acc;
	logic [31:0] rd_mux;

	assign hit_ctrl = I_PADDR == sync_burst_pkg::CTRL_OFF;
	assign hit_wptr = I_PADDR == sync_burst_pkg::WPTR_OFF;
	assign hit_wdata = I_PADDR == sync_burst_pkg::WDATA_OFF;
	assign hit_start = I_PADDR == sync_burst_pkg::START_OFF;
	assign hit_stat = I_PADDR == sync_burst_pkg::STATUS_OFF;
	assign mapped = hit_ctrl | hit_wptr | hit_wdata | hit_start | hit_stat;
	assign setup = I_PSEL & ~I_PENABLE;
	assign wr_acc = I_PSEL & I_PENABLE & I_PWRITE & mapped;

	assign rd_mux = hit_ctrl ? {16'h0000, ctrl_q} :
		hit_wptr ? {24'h000000, wptr_q} :
		hit_start ? {23'h000000, start_q} :
		hit_stat ? {5'h00, stat_a[11:1], 15'h0000, stat_a[0]} : 32'h00000000;

	always_ff @(posedge I_CLK or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_q <= sync_burst_pkg::CTRL_RESET;
			start_q <= sync_burst_pkg::START_RESET;
			wptr_q <= sync_burst_pkg::WPTR_RESET;
			prdata_q <= 32'h00000000;
		end else begin
			if (wr_acc && hit_ctrl) begin
				ctrl_q <= I_PWDATA[15:0] & sync_burst_pkg::CTRL_WMASK;
			end
			if (wr_acc && hit_start) begin
				start_q <= I_PWDATA[8:0];
			end
			if (wr_acc && hit_wptr) begin
				wptr_q <= I_PWDATA[7:0];
			end else if (wr_acc && hit_wdata) begin
				wptr_q <= wptr_q + 8'h01;
			end
			if (setup) begin
				prdata_q <= rd_mux;
			end
		end
	end

	assign O_PRDATA = prdata_q;
	assign O_PREADY = 1'b1;
	assign O_PSLVERR = I_PSEL & I_PENABLE & ~mapped;

	// ****************************************************************
	// Crossings
	// ****************************************************************
	logic [24:0] cfg_l;
	logic [11:0] stat_l;
	logic l_en;
	logic l_inv;
	logic l_hold;
	logic [3:0] l_lat;
	logic [3:0] l_len;
	logic l_byte;
	logic [7:0] l_start;

	burst_sync2 #(.W(25)) u_cfg_sync (
		.i_clk(I_BCLK),
		.i_rst_b(lrst_b),
		.i_d({start_q, ctrl_q}),
		.o_q(cfg_l)
	);

	// The count is exact once the burst has ended, even with the burst clock running; a read during a burst may see a torn value.
	burst_sync2 #(.W(12)) u_stat_sync (
		.i_clk(I_CLK),
		.i_rst_b(rst_b),
		.i_d(stat_l),
		.o_q(stat_a)
	);

	assign l_en = cfg_l[sync_burst_pkg::EN_BIT];
	assign l_inv = cfg_l[sync_burst_pkg::INV_BIT];
	assign l_hold = cfg_l[sync_burst_pkg::HOLD_BIT];
	assign l_lat = cfg_l[sync_burst_pkg::LAT_LSB +: sync_burst_pkg::LAT_W];
	assign l_len = cfg_l[sync_burst_pkg::LEN_LSB +: sync_burst_pkg::LEN_W];
	assign l_byte = cfg_l[16 + sync_burst_pkg::START_BYTE_BIT];
	assign l_start = cfg_l[23:16];

	// ****************************************************************
	// Strobe sampling on the burst clock
	// ****************************************************************
	logic act_r_q;
	logic act_f_q;
	logic act;

	always_ff @(posedge I_BCLK or negedge lrst_b) begin
		if (!lrst_b) begin
			act_r_q <= 1'b0;
		end else begin
			act_r_q <= ~I_CE_B & ~I_OE_B;
		end
	end

	always_ff @(negedge I_BCLK or negedge lrst_b) begin
		if (!lrst_b) begin
			act_f_q <= 1'b0;
		end else begin
			act_f_q <= ~I_CE_B & ~I_OE_B;
		end
	end

	// Sampled strobes never reach the engine while disabled; the burst clock still clocks it.
	assign act = l_en & (l_inv ? act_f_q : act_r_q);

	// ****************************************************************
	// Burst engine
	// ****************************************************************
	typedef enum logic [1:0] {IDLE, WAIT, DRIVE, DONE} state_t;

	function automatic logic [sync_burst_pkg::CNT_W-1:0] burst_units(input logic [3:0] len, input logic hold);
		logic [sync_burst_pkg::CNT_W-1:0] one;
		one = {{(sync_burst_pkg::CNT_W-1){1'b0}}, 1'b1};
		// Counter covers a length of ten at most with hold clear, eleven with hold set.
		if (hold && len != 4'h0) begin
			burst_units = one << (len - 4'h1);
		end else if (hold) begin
			burst_units = one;
		end else begin
			burst_units = one << len;
		end
	endfunction : burst_units

	state_t state_q;
	state_t state_d;
	logic [sync_burst_pkg::DLY_W-1:0] wait_q;
	logic [sync_burst_pkg::DLY_W-1:0] wait_d;
	logic [sync_burst_pkg::DLY_W-1:0] dly;
	logic [sync_burst_pkg::CNT_W-1:0] left_q;
	logic [sync_burst_pkg::CNT_W-1:0] left_d;
	logic [sync_burst_pkg::CNT_W-1:0] done_q;
	logic [sync_burst_pkg::CNT_W-1:0] done_d;
	logic [sync_burst_pkg::UNIT_AW-1:0] addr_q;
	logic [sync_burst_pkg::UNIT_AW-1:0] addr_d;
	logic hold_q;
	logic hold_d;
	logic [15:0] d_q;
	logic [15:0] d_d;
	logic oe_q;
	logic oe_d;
	logic [15:0] rdata;
	logic [7:0] raddr;
	logic [15:0] unit;

	// One clock of extra delay in the falling edge case.
	assign dly = {1'b0, l_lat} + {4'h0, l_inv};
	assign raddr = l_byte ? addr_d[8:1] : addr_d[7:0];
	assign unit = l_byte ? {8'h00, (addr_q[0] ? rdata[15:8] : rdata[7:0])} : rdata;

	burst_mem u_mem (
		.i_wclk(I_CLK),
		.i_we(wr_acc & hit_wdata),
		.i_waddr(wptr_q),
		.i_wdata(I_PWDATA[15:0]),
		.i_rclk(I_BCLK),
		.i_raddr(raddr),
		.o_rdata(rdata)
	);

	always_comb begin
		state_d = state_q;
		wait_d = wait_q;
		left_d = left_q;
		done_d = done_q;
		addr_d = addr_q;
		hold_d = hold_q;
		d_d = d_q;
		oe_d = oe_q;
		unique case (state_q)
			IDLE: begin
				// Read data always shows the unit at the start address.
				addr_d = {1'b0, l_start};
				if (act) begin
					done_d = '0;
					left_d = burst_units(l_len, l_hold);
					if (dly == '0) begin
						state_d = DRIVE;
						wait_d = '0;
					end else begin
						state_d = WAIT;
						wait_d = dly - 5'h01;
					end
				end
			end
			WAIT: begin
				if (wait_q != '0) begin
					wait_d = wait_q - 5'h01;
				end
			end
			DRIVE: begin
				if (hold_q) begin
					hold_d = 1'b0;
				end else if (left_q == '0) begin
					state_d = DONE;
					oe_d = 1'b0;
				end
			end
			DONE: begin
				oe_d = 1'b0;
			end
		endcase
		// Present the next unit when the wait or previous word ends.
		if ((state_q == IDLE && act && dly == '0) || (state_q == WAIT && wait_q == '0) ||
			(state_q == DRIVE && !hold_q && left_q != '0)) begin
			if (state_q == IDLE) begin
				left_d = burst_units(l_len, l_hold) - 11'h001;
				addr_d = {1'b0, l_start} + 9'h001;
			end else begin
				left_d = left_q - 11'h001;
				addr_d = addr_q + 9'h001;
			end
			state_d = DRIVE;
			d_d = unit;
			oe_d = 1'b1;
			hold_d = l_hold;
			done_d = done_d + 11'h001;
		end
		if (state_q != IDLE && !act) begin
			state_d = IDLE;
			oe_d = 1'b0;
			hold_d = 1'b0;
		end
	end

	always_ff @(posedge I_BCLK or negedge lrst_b) begin
		if (!lrst_b) begin
			state_q <= IDLE;
			wait_q <= '0;
			left_q <= '0;
			done_q <= '0;
			addr_q <= '0;
			hold_q <= 1'b0;
			d_q <= 16'h0000;
			oe_q <= 1'b0;
		end else begin
			state_q <= state_d;
			wait_q <= wait_d;
			left_q <= left_d;
			done_q <= done_d;
			addr_q <= addr_d;
			hold_q <= hold_d;
			d_q <= d_d;
			oe_q <= oe_d;
		end
	end

	assign stat_l = {done_q, state_q != IDLE};
	assign O_D = d_q;
	assign O_D_OE = oe_q;
endmodule : sync_burst_read

// *** rtl/sync_burst_pkg.sv ***
// Constants shared by the synchronous burst read control block.
package sync_burst_pkg;
	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [15:0] CTRL_OFF = 16'h101c;
	localparam logic [15:0] WPTR_OFF = 16'h1020;
	localparam logic [15:0] WDATA_OFF = 16'h1024;
	localparam logic [15:0] START_OFF = 16'h1028;
	localparam logic [15:0] STATUS_OFF = 16'h102c;
	// ****************************************************************
	// Control register fields
	// ****************************************************************
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [15:0] CTRL_WMASK = 16'hff07;
	localparam int EN_BIT = 0;
	localparam int INV_BIT = 1;
	localparam int HOLD_BIT = 2;
	localparam int LAT_LSB = 8;
	localparam int LAT_W = 4;
	localparam int LEN_LSB = 12;
	localparam int LEN_W = 4;
	// ****************************************************************
	// Start register fields, data store and counts
	// ****************************************************************
	localparam int START_BYTE_BIT = 8;
	localparam logic [8:0] START_RESET = 9'h000;
	localparam logic [7:0] WPTR_RESET = 8'h00;
	localparam int MEM_AW = 8;
	localparam int MEM_DW = 16;
	localparam int UNIT_AW = 9;
	localparam int CNT_W = 11;
	localparam int STAT_CNT_LSB = 16;
	localparam int DLY_W = 5;
endpackage : sync_burst_pkg

// *** rtl/burst_sync2.sv ***
// Two flip-flop synchroniser for levels and quasi-static words.
`timescale 1ns/1ps
module burst_sync2 #(
	parameter int W = 1
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);
	logic [W-1:0] meta_q;

	// Words pass on every clock, so bits can tear if the sender changes them while they cross.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			meta_q <= '0;
			o_q <= '0;
		end else begin
			meta_q <= i_d;
			o_q <= meta_q;
		end
	end
endmodule : burst_sync2

// *** rtl/burst_mem.sv ***
// Burst data store: written from the register clock, read on the burst clock.
`timescale 1ns/1ps
module burst_mem (
	input wire logic i_wclk,
	input wire logic i_we,
	input wire logic [sync_burst_pkg::MEM_AW-1:0] i_waddr,
	input wire logic [sync_burst_pkg::MEM_DW-1:0] i_wdata,
	input wire logic i_rclk,
	input wire logic [sync_burst_pkg::MEM_AW-1:0] i_raddr,
	output logic [sync_burst_pkg::MEM_DW-1:0] o_rdata
);
	logic [sync_burst_pkg::MEM_DW-1:0] mem_q [0:(1<<sync_burst_pkg::MEM_AW)-1];

	always_ff @(posedge i_wclk) begin
		if (i_we) begin
			mem_q[i_waddr] <= i_wdata;
		end
	end

	// Software must not load words while a burst is running.
	always_ff @(posedge i_rclk) begin
		o_rdata <= mem_q[i_raddr];
	end
endmodule : burst_mem

// *** bench/sync_burst_read_assertions.sv ***
// Port checker for the synchronous burst read block.
`timescale 1ns/1ps
module sync_burst_read_assertions (
	input wire logic I_CLK,
	input wire logic I_RST_B,
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [15:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	input wire logic [31:0] O_PRDATA,
	input wire logic O_PREADY,
	input wire logic O_PSLVERR,
	input wire logic I_BCLK,
	input wire logic I_CE_B,
	input wire logic I_OE_B,
	input wire logic [15:0] O_D,
	input wire logic O_D_OE
);
	// ****
	// Register bus and burst link checks.
	// ****
	wire acc = I_PSEL && I_PENABLE;
	wire rd = acc && !I_PWRITE;
	wire near = I_PADDR >= 16'h101c && I_PADDR <= 16'h102c;
	wire mapped = near && I_PADDR[1:0] == 2'h0;
	wire rel = I_CE_B || I_OE_B;
	sequence s_released;
		rel [*3];
	endsequence
	logic en_seen;
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			en_seen <= 1'b0;
		end else if (acc && I_PWRITE && I_PADDR == 16'h101c) begin
			en_seen <= I_PWDATA[0];
		end
	end
	a_quiet_when_off: assert property (@(posedge I_BCLK) disable iff (!I_RST_B) !en_seen |-> !O_D_OE)
		else $error("drive while disabled");
	a_ready_high: assert property (@(posedge I_CLK) disable iff (!I_RST_B) O_PREADY) else $error("ready low");
	a_err_in_access: assert property (@(posedge I_CLK) disable iff (!I_RST_B) O_PSLVERR |-> acc)
		else $error("stray error");
	a_mapped_ok: assert property (@(posedge I_CLK) disable iff (!I_RST_B) acc && mapped |-> !O_PSLVERR)
		else $error("mapped error");
	a_unmapped_err: assert property (@(posedge I_CLK) disable iff (!I_RST_B) acc && !near |-> O_PSLVERR)
		else $error("no error");
	a_unmapped_zero: assert property (@(posedge I_CLK) disable iff (!I_RST_B) rd && !near |-> O_PRDATA == 0)
		else $error("unmapped data");
	a_reserved_zero: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
		rd && I_PADDR == 16'h101c |-> O_PRDATA[31:16] == 16'h0 && O_PRDATA[7:3] == 5'h0) else $error("reserved set");
	a_drive_after_strobe: assert property (@(posedge I_BCLK) disable iff (!I_RST_B)
		$rose(O_D_OE) |-> $past(!rel)) else $error("drive without strobes");
	a_stop_released: assert property (@(posedge I_BCLK) disable iff (!I_RST_B)
		s_released |-> !O_D_OE) else $error("drive after release");
endmodule : sync_burst_read_assertions

// *** bench/burst_host.sv ***
// Host memory controller model: burst clock, strobes and data capture.
`timescale 1ns/1ps
module burst_host (
	output logic o_bclk,
	output logic o_ce_b,
	output logic o_oe_b,
	input wire logic [15:0] i_d,
	input wire logic i_d_oe
);
	logic [15:0] got[$];
	int first;
	initial begin
		o_bclk = 1'b0;
		o_ce_b = 1'b1;
		o_oe_b = 1'b1;
	end
	// ****
	// The clock runs only inside a task; data is taken just before each rising edge.
	// ****
	task automatic cycle(input int n);
		for (int i = 0; i < n; i++) begin
			#14;
			if (i_d_oe === 1'b1) begin
				if (got.size() == 0) first = i;
				got.push_back(i_d);
			end
			#1 o_bclk = 1'b1;
			#15 o_bclk = 1'b0;
		end
	endtask : cycle
	// Strobes move 3 ns into the low phase so that neither sampling edge races them.
	task automatic burst(input int n);
		got.delete();
		first = -1;
		#3;
		o_ce_b = 1'b0;
		o_oe_b = 1'b0;
		cycle(n);
		#3;
		o_ce_b = 1'b1;
		o_oe_b = 1'b1;
		cycle(3);
	endtask : burst
endmodule : burst_host

// *** bench/sync_burst_read_bench.sv ***
// Self-checking bench for the synchronous burst read block.
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fails++; $display("MISMATCH %0t got %h expected %h", $time, g, e); end end
module sync_burst_read_bench;
	logic I_CLK = 1'b0;
	logic I_RST_B = 1'b0;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [15:0] pa = 16'h0;
	logic [31:0] pwd = 32'h0;
	logic [31:0] prd, rv;
	logic rdy, err, ev, bclk, ce_b, oe_b, doe;
	logic [15:0] d;
	int fails = 0;
	int checked = 0;
	int cyc = 0;
	int cs[7][6] = '{'{0, 0, 0, 1, 0, 5}, '{0, 1, 3, 2, 0, 20}, '{1, 0, 2, 3, 0, 0}, '{0, 1, 0, 0, 0, 63},
		'{1, 1, 1, 1, 0, 7}, '{0, 0, 15, 4, 1, 9}, '{0, 0, 1, 6, 0, 0}};
	always #12.5 I_CLK = ~I_CLK;
	sync_burst_read uut (.I_CLK(I_CLK), .I_RST_B(I_RST_B), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
		.I_PADDR(pa), .I_PWDATA(pwd), .O_PRDATA(prd), .O_PREADY(rdy), .O_PSLVERR(err), .I_BCLK(bclk),
		.I_CE_B(ce_b), .I_OE_B(oe_b), .O_D(d), .O_D_OE(doe));
	burst_host host (.o_bclk(bclk), .o_ce_b(ce_b), .o_oe_b(oe_b), .i_d(d), .i_d_oe(doe));
	// ****
	// Bus tasks and run control.
	// ****
	task automatic close_out;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : close_out
	always @(posedge I_CLK) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			close_out();
		end
	end
	task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] wd);
		@(posedge I_CLK);
		psel <= 1'b1;
		pwr <= w;
		pa <= a;
		pwd <= wd;
		@(posedge I_CLK);
		pen <= 1'b1;
		do @(posedge I_CLK); while (rdy !== 1'b1);
		rv = prd;
		ev = err;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb
	function automatic logic [15:0] pat(input int k);
		return {~k[7:0], k[7:0]};
	endfunction : pat
	initial begin
		fork
			host.cycle(4);
			repeat (16) @(posedge I_CLK);
		join
		I_RST_B <= 1'b1;
		host.cycle(4);
		apb(0, 16'h101c, 0);
		`CHK(rv, 32'h0)
		apb(1, 16'h101c, 32'h0000a0ff);
		apb(0, 16'h101c, 0);
		`CHK(rv, 32'h0000a007)
		apb(0, 16'h1030, 0);
		`CHK(ev, 1'b1)
		apb(1, 16'h1020, 0);
		for (int k = 0; k < 64; k++) apb(1, 16'h1024, {16'h0, pat(k)});
		apb(0, 16'h1020, 0);
		`CHK(rv, 32'h40)
		apb(0, 16'h1024, 0);
		`CHK(rv, 32'h0)
		apb(1, 16'h101c, 32'h1f06);
		host.cycle(4);
		host.burst(30);
		`CHK(host.got.size(), 0)
		foreach (cs[t]) begin
			int n;
			int r;
			int u;
			logic [15:0] w;
			r = cs[t][1] + 1;
			n = cs[t][1] ? (cs[t][3] == 0 ? 1 : 1 << (cs[t][3] - 1)) : 1 << cs[t][3];
			apb(1, 16'h101c, {16'h0, cs[t][3][3:0], cs[t][2][3:0], 5'h0, cs[t][1][0], cs[t][0][0], 1'b1});
			apb(1, 16'h1028, {23'h0, cs[t][4][0], cs[t][5][7:0]});
			host.cycle(4);
			host.burst(cs[t][2] + n * r + 6);
			`CHK(host.first, 2 + cs[t][2] + cs[t][0])
			`CHK(host.got.size(), n * r)
			for (int i = 0; i < host.got.size(); i++) begin
				u = cs[t][5] + i / r;
				w = cs[t][4] ? pat(u >> 1) : pat(u);
				if (cs[t][4]) w = {8'h0, u[0] ? w[15:8] : w[7:0]};
				`CHK(host.got[i], w)
			end
			apb(0, 16'h1028, 0);
			`CHK(rv, {23'h0, cs[t][4][0], cs[t][5][7:0]})
			apb(0, 16'h102c, 0);
			`CHK(rv, n << 16)
		end
		host.burst(5);
		`CHK(host.got.size(), 4)
		`CHK(host.got[3], pat(3))
		host.burst(10);
		`CHK(host.first, 3)
		close_out();
	end
endmodule : sync_burst_read_bench
bind sync_burst_read sync_burst_read_assertions chk (.I_CLK(I_CLK), .I_RST_B(I_RST_B), .I_PSEL(I_PSEL),
	.I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA),
	.O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .I_BCLK(I_BCLK), .I_CE_B(I_CE_B), .I_OE_B(I_OE_B),
	.O_D(O_D), .O_D_OE(O_D_OE));
